// file: vvoc_ctrl.sv
// Purpose: Open-side and close-side output control of a motorised valve
// Assumes: Inputs synchronous to clk_in; percent values in tenths of a percent
// Notes: Works with or without a position feedback input
// Functional notes
// [RULE1] On feedback error, act as at STOP when the error setting is 0, else keep control.
// [RULE2] Motor travel time is held, settable 5 to 1000 s, default 10 s.
// [RULE3] Calibration computes travel time and keeps the old one if the result is under 5 s.
// [RULE4] At STOP the 2-bit code selects both off, close on, or open on; default 0.
// [RULE5] At full travel the matching output turns off when the saturation setting is 0; the code applies this only with feedback fitted.
// [RULE6] Calibration records closed and open readings; 0 to 100 % maps onto that span.
// [RULE7] Calibration starts after shift is held 5 s at preparation and returns there.
// [RULE8] Parameter entry returns to monitor after 1 minute idle, but not while calibrating.
// [RULE9] Without feedback, accumulated on-time in one direction is limited to a share of travel time; 0 disables.
// [RULE10] Turning on the opposite output clears the accumulated on-time.
// [RULE11] Both outputs stay off inside the neutral zone, 0.1 to 10.0 %, default 2.0.
// [RULE12] Outputs switch with a differential gap, 0.1 to 5.0 %, default 1.0.
// [RULE13] Limiter only without feedback; error action and calibration only with it.
// [RULE14] Open and close outputs are never on together.

`timescale 1ns/100ps

module vvoc_ctrl
  import vvoc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter logic [10:0] NZ_DEF = 11'h014,
  parameter logic [10:0] GAP_DEF = 11'h00A,
  parameter logic [10:0] LIM_DEF = 11'h5DC
)(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Control inputs
  input wire logic run_in,
  input wire logic signed [PCT_W-1:0] manipulated_value_in,
  // Position feedback
  input wire logic fb_fitted_in,
  input wire logic fb_error_in,
  input wire logic [FB_W-1:0] position_feedback_input_in,
  // Settings
  input wire logic err_action_in,
  input wire logic [1:0] stop_action_in,
  input wire logic sat_action_in,
  input wire logic [10:0] neutral_zone_in,
  input wire logic [10:0] diff_gap_in,
  input wire logic [10:0] int_limit_in,
  input wire logic settings_load_in,
  input wire logic [TT_W-1:0] travel_time_in,
  input wire logic travel_load_in,
  // Operator keys
  input wire logic param_entry_in,
  input wire logic cal_prep_in,
  input wire logic shift_key_in,
  input wire logic key_activity_in,
  // Outputs
  output logic open_side_output_out,
  output logic close_side_output_out,
  output logic [TT_W-1:0] travel_time_out,
  output logic signed [PCT_W-1:0] position_out,
  output logic cal_busy_out,
  output logic monitor_return_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic signed [PCT_W-1:0] map_pos(
    input logic [FB_W-1:0] fb, input logic [FB_W-1:0] lo, input logic [FB_W-1:0] hi);
    logic signed [FB_W+12:0] num;
    logic signed [FB_W+12:0] den;
    num = (signed'({1'b0, fb}) - signed'({1'b0, lo})) * signed'({1'b0, PCT_SCALE});
    den = signed'({1'b0, hi}) - signed'({1'b0, lo});
    if (den <= 0) begin
      den = (FB_W+13)'(1);
    end
    map_pos = PCT_W'(num / den);
  endfunction

  function automatic logic in_range(input logic [10:0] v, input logic [10:0] lo,
    input logic [10:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  vvoc_cal_if cal_if ();

  vvoc_cal u_cal (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .cal_if(cal_if)
  );

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] div_q;
  logic tick_q;
  logic tick_d_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      div_q <= '0;
      tick_q <= 1'b0;
      tick_d_q <= 1'b0;
    end else begin
      tick_q <= div_q == CNT_W'(TICK_CYCLES - 1);
      tick_d_q <= tick_q;
      div_q <= (div_q == CNT_W'(TICK_CYCLES - 1)) ? '0 : div_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Stored settings
  // ----------------------------------------------------------------
  logic [TT_W-1:0] travel_q;
  logic [10:0] nz_q;
  logic [10:0] gap_q;
  logic [10:0] lim_q;
  wire travel_in_ok = (travel_time_in >= TRAVEL_MIN_S) && (travel_time_in <= TRAVEL_MAX_S);
  wire cal_update = cal_if.done && cal_if.travel_ok && fb_fitted_in;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      travel_q <= TRAVEL_DEF_S;
      nz_q <= NZ_DEF;
      gap_q <= GAP_DEF;
      lim_q <= LIM_DEF;
    end else begin
      if (cal_update) begin
        travel_q <= cal_if.travel_s; // RULE3
      end else if (travel_load_in && travel_in_ok) begin
        travel_q <= travel_time_in; // RULE2
      end
      if (settings_load_in) begin
        if (in_range(neutral_zone_in, SET_MIN, NZ_MAX)) begin
          nz_q <= neutral_zone_in; // RULE11
        end
        if (in_range(diff_gap_in, SET_MIN, GAP_MAX)) begin
          gap_q <= diff_gap_in; // RULE12
        end
        if (in_range(int_limit_in, '0, LIM_MAX)) begin
          lim_q <= int_limit_in; // RULE9
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Calibration start and parameter idle timeout
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] hold_q;
  logic [CNT_W-1:0] idle_q;
  logic start_q;
  logic ret_q;
  // Hold count needs feedback fitted and no running calibration
  wire holding = fb_fitted_in && cal_prep_in && shift_key_in && !cal_if.busy;
  wire idling = param_entry_in && !key_activity_in && !cal_if.busy;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      hold_q <= '0;
      idle_q <= '0;
      start_q <= 1'b0;
      ret_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      ret_q <= 1'b0;
      if (!holding) begin
        hold_q <= '0; // RULE7
      end else if (tick_q) begin
        hold_q <= hold_q + 1'b1;
        if (hold_q == CNT_W'(HOLD_TICKS - 1)) begin
          start_q <= 1'b1; // RULE7 RULE13
          hold_q <= '0;
        end
      end
      if (!idling) begin
        idle_q <= '0; // RULE8
      end else if (tick_q) begin
        idle_q <= idle_q + 1'b1;
        if (idle_q == CNT_W'(IDLE_TICKS - 1)) begin
          ret_q <= 1'b1; // RULE8
          idle_q <= '0;
        end
      end
    end
  end

  assign cal_if.tick = tick_q;
  assign cal_if.start = start_q;
  assign cal_if.fb = position_feedback_input_in;

  // ----------------------------------------------------------------
  // Valve position: mapped feedback or run-time estimate
  // ----------------------------------------------------------------
  logic signed [PCT_W-1:0] est_q;
  logic [CNT_W-1:0] frac_q;
  logic open_q;
  logic close_q;
  wire signed [PCT_W-1:0] fb_pos = map_pos(position_feedback_input_in, cal_if.lo, cal_if.hi);
  wire signed [PCT_W-1:0] pos = fb_fitted_in ? fb_pos : est_q; // RULE6
  wire [CNT_W-1:0] step_span = CNT_W'(travel_q) * CNT_W'(TICKS_PER_S);
  wire [CNT_W-1:0] half_step = CNT_W'(PCT_SCALE >> 1);

  // Half scale at tick and one cycle later: short travel keeps up
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      est_q <= POS_ZERO;
      frac_q <= '0;
    end else if ((tick_q || tick_d_q) && (open_q || close_q)) begin
      if (frac_q + half_step >= step_span) begin
        frac_q <= frac_q + half_step - step_span;
        if (open_q && est_q < POS_FULL) begin
          est_q <= est_q + 1'b1;
        end else if (close_q && est_q > POS_ZERO) begin
          est_q <= est_q - 1'b1;
        end
      end else begin
        frac_q <= frac_q + half_step;
      end
    end
  end

  // ----------------------------------------------------------------
  // Neutral zone and differential gap
  // ----------------------------------------------------------------
  wire signed [PCT_W:0] err = manipulated_value_in - pos;
  wire signed [PCT_W:0] half_nz = signed'({5'h00, nz_q[10:1]});
  wire signed [PCT_W:0] on_lvl = half_nz + signed'({4'h0, gap_q});
  wire want_open = open_q ? (err > half_nz) : (err >= on_lvl); // RULE11 RULE12
  wire want_close = close_q ? (err < -half_nz) : (err <= -on_lvl); // RULE11 RULE12

  // ----------------------------------------------------------------
  // Integrating run-time limiter (no feedback)
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] acc_q;
  wire [CNT_W-1:0] lim_ticks = CNT_W'((32'(travel_q) * 32'(lim_q) * 32'(TICKS_PER_S))
    / 32'(PCT_SCALE));
  wire lim_hit = !fb_fitted_in && (lim_q != '0) && (acc_q >= lim_ticks); // RULE9 RULE13
  logic last_open_q;

  // Direction change restarts the run count
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      acc_q <= '0;
      last_open_q <= 1'b0;
    end else begin
      if ((open_q && !last_open_q) || (close_q && last_open_q)) begin
        acc_q <= '0; // RULE10
        last_open_q <= open_q;
      end else if (tick_q && (open_q || close_q) && !lim_hit) begin
        acc_q <= acc_q + 1'b1; // RULE9
      end
    end
  end

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  wire fb_fault_stop = fb_fitted_in && fb_error_in && (err_action_in == ERR_ACT_STOP); // RULE1
  wire stop_mode = !run_in || fb_fault_stop;
  wire at_open = fb_fitted_in && (pos >= POS_FULL) && (sat_action_in == SAT_ACT_OFF);
  wire at_closed = fb_fitted_in && (pos <= POS_ZERO) && (sat_action_in == SAT_ACT_OFF);
  wire lim_open = lim_hit && last_open_q;
  wire lim_close = lim_hit && !last_open_q;
  logic open_d;
  logic close_d;

  // Calibration drive first, then STOP, then control
  always_comb begin
    open_d = 1'b0;
    close_d = 1'b0;
    if (cal_if.busy && fb_fitted_in) begin
      open_d = cal_if.drive_open;
      close_d = cal_if.drive_close;
    end else if (stop_mode) begin
      open_d = stop_action_in == STOP_OPEN_ON; // RULE4
      close_d = stop_action_in == STOP_CLOSE_ON; // RULE4
    end else begin
      open_d = want_open && !at_open && !lim_open; // RULE5 RULE9
      close_d = want_close && !at_closed && !lim_close; // RULE5 RULE9
    end
    if (open_d && close_d) begin
      close_d = 1'b0; // RULE14
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      open_q <= 1'b0;
      close_q <= 1'b0;
    end else begin
      open_q <= open_d;
      close_q <= close_d;
    end
  end

  assign open_side_output_out = open_q;
  assign close_side_output_out = close_q;
  assign travel_time_out = travel_q;
  assign position_out = pos;
  assign cal_busy_out = cal_if.busy;
  assign monitor_return_out = ret_q;

endmodule

// file: vvoc_pkg.sv
// Purpose: Shared constants and types for the valve open/close output control
// Assumes: Clock of 50 MHz, internal timebase tick of 10 ms
// Notes: Percent values are in tenths of a percent

package vvoc_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_S = 1000 / TICK_MS;

  // ----------------------------------------------------------------
  // Times in seconds and their tick counts
  // ----------------------------------------------------------------
  localparam int HOLD_S = 5;
  localparam int IDLE_S = 60;
  localparam int STALL_S = 1;
  localparam int HOLD_TICKS = HOLD_S * TICKS_PER_S;
  localparam int IDLE_TICKS = IDLE_S * TICKS_PER_S;
  localparam int STALL_TICKS = STALL_S * TICKS_PER_S;

  // ----------------------------------------------------------------
  // Widths and ranges
  // ----------------------------------------------------------------
  localparam int FB_W = 12;
  localparam int PCT_W = 14;
  localparam int TT_W = 10;
  localparam int CNT_W = 20;
  localparam logic [TT_W-1:0] TRAVEL_MIN_S = 10'h005;
  localparam logic [TT_W-1:0] TRAVEL_MAX_S = 10'h3E8;
  localparam logic [TT_W-1:0] TRAVEL_DEF_S = 10'h00A;
  localparam logic signed [PCT_W-1:0] POS_FULL = 14'sh03E8;
  localparam logic signed [PCT_W-1:0] POS_ZERO = 14'sh0000;
  localparam logic [FB_W-1:0] FB_LO_DEF = 12'h000;
  localparam logic [FB_W-1:0] FB_HI_DEF = 12'hFFF;
  localparam logic [10:0] PCT_SCALE = 11'h3E8;
  localparam logic [10:0] SET_MIN = 11'h001;
  localparam logic [10:0] NZ_MAX = 11'h064;
  localparam logic [10:0] GAP_MAX = 11'h032;
  localparam logic [10:0] LIM_MAX = 11'h7D0;

  // ----------------------------------------------------------------
  // Setting codes
  // ----------------------------------------------------------------
  localparam logic [1:0] STOP_BOTH_OFF = 2'h0;
  localparam logic [1:0] STOP_CLOSE_ON = 2'h1;
  localparam logic [1:0] STOP_OPEN_ON = 2'h2;
  localparam logic ERR_ACT_STOP = 1'b0;
  localparam logic SAT_ACT_OFF = 1'b0;

  typedef enum logic [1:0] {
    VVOC_CAL_IDLE = 2'b00,
    VVOC_CAL_CLOSE = 2'b01,
    VVOC_CAL_OPEN = 2'b11,
    VVOC_CAL_DONE = 2'b10
  } vvoc_cal_state_t;

endpackage

// file: vvoc_cal_if.sv
// Purpose: Carrier between the output controller and its calibration engine
// Assumes: Single clock domain
// Notes: Start and done are one-cycle pulses

`timescale 1ns/100ps

interface vvoc_cal_if;
  import vvoc_pkg::*;
  logic tick;
  logic start;
  logic [FB_W-1:0] fb;
  logic busy;
  logic drive_open;
  logic drive_close;
  logic done;
  logic [FB_W-1:0] lo;
  logic [FB_W-1:0] hi;
  logic [TT_W-1:0] travel_s;
  logic travel_ok;

  modport ctl (output tick, start, fb,
    input busy, drive_open, drive_close, done, lo, hi, travel_s, travel_ok);
  modport cal (input tick, start, fb,
    output busy, drive_open, drive_close, done, lo, hi, travel_s, travel_ok);
endinterface

// file: vvoc_cal.sv
// Purpose: Feedback calibration: find closed and open readings, time the travel
// Assumes: An end stop is reached when the reading stays still for one second
// Notes: Travel time is the open run less the settle second

`timescale 1ns/100ps

module vvoc_cal
  import vvoc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Link to controller
  vvoc_cal_if.cal cal_if
);

  vvoc_cal_state_t state_q;
  logic [FB_W-1:0] ref_q;
  logic [CNT_W-1:0] still_q;
  logic [CNT_W-1:0] run_q;
  logic [FB_W-1:0] lo_q;
  logic [FB_W-1:0] hi_q;
  logic [TT_W-1:0] travel_q;
  logic ok_q;
  logic [CNT_W-1:0] run_s;
  wire moved = cal_if.fb != ref_q;
  wire settled = still_q == CNT_W'(STALL_TICKS);

  assign run_s = (run_q - CNT_W'(STALL_TICKS)) / CNT_W'(TICKS_PER_S);
  assign cal_if.busy = state_q != VVOC_CAL_IDLE;
  assign cal_if.drive_close = state_q == VVOC_CAL_CLOSE;
  assign cal_if.drive_open = state_q == VVOC_CAL_OPEN;
  assign cal_if.done = state_q == VVOC_CAL_DONE;
  assign cal_if.lo = lo_q;
  assign cal_if.hi = hi_q;
  assign cal_if.travel_s = travel_q;
  assign cal_if.travel_ok = ok_q;

  // ----------------------------------------------------------------
  // Sequence: close, record, open, record, finish
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= VVOC_CAL_IDLE;
      ref_q <= '0;
      still_q <= '0;
      run_q <= '0;
      lo_q <= FB_LO_DEF;
      hi_q <= FB_HI_DEF;
      travel_q <= TRAVEL_DEF_S;
      ok_q <= 1'b0;
    end else begin
      unique case (state_q)
        VVOC_CAL_IDLE: begin
          if (cal_if.start) begin
            state_q <= VVOC_CAL_CLOSE;
            ref_q <= cal_if.fb;
            still_q <= '0;
          end
        end
        VVOC_CAL_CLOSE: begin
          if (cal_if.tick) begin
            ref_q <= cal_if.fb;
            still_q <= moved ? '0 : still_q + 1'b1;
            if (settled) begin
              lo_q <= cal_if.fb; // RULE6
              state_q <= VVOC_CAL_OPEN;
              still_q <= '0;
              run_q <= '0;
            end
          end
        end
        VVOC_CAL_OPEN: begin
          if (cal_if.tick) begin
            ref_q <= cal_if.fb;
            run_q <= run_q + 1'b1;
            still_q <= moved ? '0 : still_q + 1'b1;
            if (settled) begin
              hi_q <= cal_if.fb; // RULE6
              travel_q <= (run_s > CNT_W'(TRAVEL_MAX_S)) ? TRAVEL_MAX_S : run_s[TT_W-1:0];
              ok_q <= run_s >= CNT_W'(TRAVEL_MIN_S); // RULE3
              state_q <= VVOC_CAL_DONE;
            end
          end
        end
        VVOC_CAL_DONE: state_q <= VVOC_CAL_IDLE;
      endcase
    end
  end

endmodule

// file: vvoc_motor_model.sv
// Purpose: Valve motor with position potentiometer for the bench
// Assumes: One position step per tick while driven, stops at both ends
// Notes: Feedback is 100 plus three counts per step

`timescale 1ns/100ps

module vvoc_motor_model
  import vvoc_pkg::*;
#(
  parameter int TICK_CYCLES = 10
)(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Drive and travel span
  input wire logic open_in,
  input wire logic close_in,
  input wire logic [11:0] travel_ticks_in,
  // Potentiometer
  output logic [FB_W-1:0] feedback_out
);
  int tick_q;
  int pos_q;
  assign feedback_out = FB_W'(100 + 3 * pos_q);
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tick_q <= 0;
      pos_q <= 0;
    end else begin
      tick_q <= (tick_q == TICK_CYCLES - 1) ? 0 : tick_q + 1;
      if (pos_q > int'(travel_ticks_in)) begin
        pos_q <= int'(travel_ticks_in);
      end else if (tick_q == 0 && open_in && !close_in && pos_q < int'(travel_ticks_in)) begin
        pos_q <= pos_q + 1;
      end else if (tick_q == 0 && close_in && !open_in && pos_q > 0) begin
        pos_q <= pos_q - 1;
      end
    end
  end
endmodule

// file: vvoc_ctrl_asserts.sv
// Purpose: Port-level checks of the valve output controller
// Assumes: Outputs registered one edge after their cause
// Notes: Stop checks skip calibration and a held shift key

`timescale 1ns/100ps

module vvoc_ctrl_asserts
  import vvoc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Watched inputs
  input wire logic run_in,
  input wire logic fb_fitted_in,
  input wire logic fb_error_in,
  input wire logic err_action_in,
  input wire logic [1:0] stop_action_in,
  input wire logic sat_action_in,
  input wire logic [TT_W-1:0] travel_time_in,
  input wire logic travel_load_in,
  input wire logic cal_prep_in,
  input wire logic shift_key_in,
  // Watched outputs
  input wire logic open_side_output_out,
  input wire logic close_side_output_out,
  input wire logic [TT_W-1:0] travel_time_out,
  input wire logic signed [PCT_W-1:0] position_out,
  input wire logic cal_busy_out,
  input wire logic monitor_return_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire logic halt_w;
  wire logic sat_w;
  wire logic tt_ok_w;
  assign halt_w = !reset_in && !cal_busy_out && !shift_key_in
    && (!run_in || (fb_fitted_in && fb_error_in && err_action_in == ERR_ACT_STOP));
  assign sat_w = !reset_in && run_in && fb_fitted_in && !fb_error_in && !cal_busy_out
    && sat_action_in == SAT_ACT_OFF;
  assign tt_ok_w = travel_time_in >= TRAVEL_MIN_S && travel_time_in <= TRAVEL_MAX_S;

  chk_never_both: assert property (!(open_side_output_out && close_side_output_out))
    else $error("open and close on together");
  chk_stop_off: assert property ($past(halt_w && stop_action_in[1] == stop_action_in[0])
    |-> !open_side_output_out && !close_side_output_out) else $error("stop code off broken");
  chk_stop_close: assert property ($past(halt_w && stop_action_in == STOP_CLOSE_ON)
    |-> close_side_output_out && !open_side_output_out) else $error("stop code close broken");
  chk_stop_open: assert property ($past(halt_w && stop_action_in == STOP_OPEN_ON)
    |-> open_side_output_out && !close_side_output_out) else $error("stop code open broken");
  chk_travel_range: assert property (travel_time_out >= TRAVEL_MIN_S
    && travel_time_out <= TRAVEL_MAX_S) else $error("travel time out of range");
  chk_travel_load: assert property (travel_load_in && tt_ok_w && !cal_busy_out
    |=> travel_time_out == $past(travel_time_in)) else $error("travel time not loaded");
  chk_travel_keep: assert property (!(travel_load_in && tt_ok_w) && !cal_busy_out
    |=> $stable(travel_time_out)) else $error("travel time changed");
  chk_cal_start: assert property ($rose(cal_busy_out) |-> $past(shift_key_in, 2)
    && $past(cal_prep_in, 2) && $past(fb_fitted_in, 2)) else $error("calibration start wrong");
  chk_sat_open: assert property ($past(sat_w && position_out >= POS_FULL)
    |-> !open_side_output_out) else $error("open on at full open");
  chk_sat_close: assert property ($past(sat_w && position_out <= POS_ZERO)
    |-> !close_side_output_out) else $error("close on at full closed");
  chk_monitor_pulse: assert property (monitor_return_out
    |-> !cal_busy_out ##1 !monitor_return_out) else $error("monitor return pulse wrong");
endmodule

bind vvoc_ctrl vvoc_ctrl_asserts u_chk (.clk_in(clk_in), .reset_in(reset_in), .run_in(run_in),
  .fb_fitted_in(fb_fitted_in), .fb_error_in(fb_error_in), .err_action_in(err_action_in),
  .stop_action_in(stop_action_in), .sat_action_in(sat_action_in),
  .travel_time_in(travel_time_in), .travel_load_in(travel_load_in), .cal_prep_in(cal_prep_in),
  .shift_key_in(shift_key_in), .open_side_output_out(open_side_output_out),
  .close_side_output_out(close_side_output_out), .travel_time_out(travel_time_out),
  .position_out(position_out), .cal_busy_out(cal_busy_out),
  .monitor_return_out(monitor_return_out));

// file: vvoc_ctrl_bench.sv
// Purpose: Self-checking bench of the valve output controller
// Assumes: Tick shortened to 5 clocks
// Notes: Motor model closes the feedback loop

`timescale 1ns/100ps

module vvoc_ctrl_bench;
  import vvoc_pkg::*;
  localparam int TK = 5;
  logic clk_in, reset_in, run_in, fb_fit, fb_err, err_act, sat_act, set_ld, tt_ld;
  logic entry, prep, shift, key, open_o, close_o, busy_o, mon_o;
  logic [1:0] stop_c;
  logic signed [PCT_W-1:0] mv, pos_o;
  logic [10:0] nz, gap, lim;
  logic [TT_W-1:0] tt_in, tt_o, exp_tt;
  logic [11:0] m_ticks;
  logic [FB_W-1:0] fb_w;
  logic [TT_W-1:0] tv [5];
  int err_total, comparisons, pulses, seed_v;

  vvoc_ctrl #(.TICK_CYCLES(TK)) u_dut (.clk_in(clk_in), .reset_in(reset_in), .run_in(run_in),
    .manipulated_value_in(mv), .fb_fitted_in(fb_fit), .fb_error_in(fb_err),
    .position_feedback_input_in(fb_w), .err_action_in(err_act), .stop_action_in(stop_c),
    .sat_action_in(sat_act), .neutral_zone_in(nz), .diff_gap_in(gap), .int_limit_in(lim),
    .settings_load_in(set_ld), .travel_time_in(tt_in), .travel_load_in(tt_ld),
    .param_entry_in(entry), .cal_prep_in(prep), .shift_key_in(shift),
    .key_activity_in(key), .open_side_output_out(open_o), .close_side_output_out(close_o),
    .travel_time_out(tt_o), .position_out(pos_o), .cal_busy_out(busy_o),
    .monitor_return_out(mon_o));
  vvoc_motor_model #(.TICK_CYCLES(TK)) u_motor (.clk_in(clk_in), .reset_in(reset_in),
    .open_in(open_o), .close_in(close_o), .travel_ticks_in(m_ticks), .feedback_out(fb_w));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_busy(input logic lvl, input int lim_cyc);
    int n;
    n = 0;
    while (busy_o !== lvl && n < lim_cyc) begin
      wt(1);
      n++;
    end
    check(busy_o, lvl, "busy wait");
  endtask
  function automatic logic [1:0] stop_exp(input logic [1:0] code);
    return (code == STOP_CLOSE_ON) ? 2'h1 : (code == STOP_OPEN_ON) ? 2'h2 : 2'h0;
  endfunction
  function automatic int lim_ticks(input int tt, input int l);
    return tt * l * 100 / 1000;
  endfunction
  function automatic logic [TT_W-1:0] cal_exp(input int run, input logic [TT_W-1:0] old);
    return (run / 100 >= 5) ? TT_W'(run / 100) : old;
  endfunction
  task stop_test;
    $display("Counts: %0d mismatches, %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog, pulse counter
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    err_total++;
    stop_test();
  end
  always @(posedge clk_in) begin
    if (mon_o === 1'b1) pulses++;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {reset_in, run_in, fb_fit, fb_err, err_act, sat_act, set_ld, tt_ld} = 8'h80;
    {entry, prep, shift, key, stop_c} = 6'h00;
    mv = 14'sh0000;
    nz = 11'h014;
    gap = 11'h00A;
    lim = 11'h5DC;
    tt_in = 10'h00A;
    m_ticks = 12'h258;
    tv = '{10'h004, 10'h3E9, 10'h005, 10'h3E8, 10'h00A};
    seed_v = $urandom(32'hE705);
    wt(2);
    reset_in = 1'b0;
    check(tt_o, TRAVEL_DEF_S, "travel default");
    check({open_o, close_o}, 2'h0, "outputs after reset");
    $display("Test reset done");
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 4; c++) begin
        mv = PCT_W'($urandom_range(1000, 500));
        {run_in, fb_fit, fb_err} = (m != 0) ? 3'h7 : 3'h0;
        err_act = (m == 2);
        stop_c = c[1:0];
        wt(3);
        check({open_o, close_o}, (m == 2) ? 2'h2 : stop_exp(c[1:0]), "stop code");
      end
    end
    {run_in, fb_err, stop_c} = 4'h0;
    $display("Test stop codes done");
    exp_tt = tt_o;
    for (int i = 0; i < 5; i++) begin
      exp_tt = (tv[i] >= TRAVEL_MIN_S && tv[i] <= TRAVEL_MAX_S) ? tv[i] : exp_tt;
      tt_in = tv[i];
      tt_ld = 1'b1;
      wt(1);
      tt_ld = 1'b0;
      wt(1);
      check(tt_o, exp_tt, "travel load");
    end
    $display("Test travel load done");
    tt_in = 10'h005;
    lim = 11'h1F4;
    {tt_ld, set_ld} = 2'h3;
    wt(1);
    {tt_ld, set_ld, fb_fit, run_in} = 4'h1;
    mv = -14'sh0064;
    wt(3);
    mv = 14'sh03E8;
    wtk_open: begin
      wt((lim_ticks(5, 500) - 5) * TK);
      check(open_o, 1'b1, "limiter not yet");
      wt(10 * TK);
      check(open_o, 1'b0, "limiter forced off");
    end
    mv = 14'sh0000;
    wt(3);
    check(close_o, 1'b1, "opposite output on");
    wt(20 * TK);
    mv = 14'sh03E8;
    wt(3);
    check(open_o, 1'b1, "count cleared");
    {run_in, fb_fit, prep, shift} = 4'h7;
    $display("Test limiter done");
    wt(490 * TK);
    check(busy_o, 1'b0, "no early calibration");
    wait_busy(1'b1, 30 * TK);
    shift = 1'b0;
    wait_busy(1'b0, 2000 * TK);
    exp_tt = cal_exp(600, exp_tt);
    check(tt_o, exp_tt, "travel from calibration");
    check(pos_o, POS_FULL, "open end maps to full");
    prep = 1'b0;
    run_in = 1'b1;
    mv = -14'sh0032;
    wt(700 * TK);
    check(close_o, 1'b0, "close off at closed end");
    check(pos_o, POS_ZERO, "closed end maps to zero");
    sat_act = 1'b1;
    wt(3);
    check(close_o, 1'b1, "close held at closed end");
    mv = 14'sh000F;
    wt(3);
    check({open_o, close_o}, 2'h0, "neutral zone off");
    mv = 14'sh0014;
    wt(3);
    mv = 14'sh000F;
    wt(3);
    check(open_o, 1'b1, "gap holds open");
    $display("Test calibration done");
    {run_in, prep, shift} = 3'h3;
    m_ticks = 12'h12C;
    wait_busy(1'b1, 600 * TK);
    shift = 1'b0;
    wait_busy(1'b0, 2000 * TK);
    check(tt_o, cal_exp(300, exp_tt), "short travel kept old");
    prep = 1'b0;
    $display("Test short calibration done");
    pulses = 0;
    entry = 1'b1;
    wt(5990 * TK);
    check(16'(pulses), 16'h0000, "no early return");
    wt(20 * TK);
    check(16'(pulses), 16'h0001, "idle return");
    $display("Test idle return done");
    stop_test();
  end
endmodule
